//--- core/ecd_map.vh
// Register offsets, field positions, reset values and timing counts of the calibration datapath.
// Assumes a plain register port with word indices as addresses.
`ifndef ECD_MAP_VH
`define ECD_MAP_VH
`define ECD_PGAIN_A      16'h4389
`define ECD_WOS_A        16'h438a
`define ECD_PGAIN_B      16'h438b
`define ECD_WOS_B        16'h438c
`define ECD_PGAIN_C      16'h438d
`define ECD_WOS_C        16'h438e
`define ECD_FWOS_A       16'h43a2
`define ECD_FWOS_B       16'h43a3
`define ECD_FWOS_C       16'h43a4
`define ECD_FVAROS_A     16'h43a5
`define ECD_FVAROS_B     16'h43a6
`define ECD_FVAROS_C     16'h43a7
`define ECD_DCOMP_A      16'he614
`define ECD_DCOMP_B      16'he615
`define ECD_DCOMP_C      16'he616
`define ECD_THR_SET      16'hea00
`define ECD_DIV_A        16'he611
`define ECD_DIV_B        16'he612
`define ECD_DIV_C        16'he613
`define ECD_IRMS_A       16'h43c0
`define ECD_VRMS_A       16'h43c1
`define ECD_IRMS_B       16'h43c2
`define ECD_VRMS_B       16'h43c3
`define ECD_IRMS_C       16'h43c4
`define ECD_VRMS_C       16'h43c5
`define ECD_DCOMP_POS    9
`define ECD_GAIN_FRAC    23
`define ECD_THR_LOW      27
`define ECD_THR_RST      8'h03
`define ECD_DIV_RST      16'h0db3
`define ECD_DELAY_DEPTH  512
`endif

//--- core/ecd_datapath.v
// Per-phase calibration stage: delay correction, power gain, power offsets,
// energy accumulation against a threshold and divided energy pulses.
// Assumes samples arrive synchronously with sample_valid at the sampling rate.
`include "ecd_map.vh"

// ----------------------------------------------------------------------------
// Calibration datapath
// ----------------------------------------------------------------------------
// Function
// - Current or voltage is delayed against the other by whole sample steps.
// - Delay field is a magnitude; bit nine chooses positive error correction.
// - Each phase keeps and applies its own delay value.
// - Power is scaled by one plus signed gain over two to the 23.
// - One gain scales active, fundamental active, reactive and apparent power.
// - Phases B and C have their own gain registers.
// - A signed total active offset is added per phase.
// - Threshold is the 8-bit setting above 27 zero bits.
// - A fundamental active offset corrects fundamental active power likewise.
// - Fundamental reactive offsets are applied per phase likewise.
// - Current and voltage rms results are readable registers.
// - Active and reactive pulses are available at the same time.
// - Both pulse outputs of a phase divide accumulated pulses by that phase's one divider.
module ecd_datapath #(
  parameter DW     = 24,
  parameter DEPTH  = `ECD_DELAY_DEPTH
) (
  input  wire              clock,
  input  wire              sys_rst,
  input  wire [15:0]       reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  input  wire              sample_valid,
  input  wire [3*DW-1:0]   volt_in,
  input  wire [3*DW-1:0]   curr_in,
  input  wire [3*DW-1:0]   volt_rms_in,
  input  wire [3*DW-1:0]   curr_rms_in,
  input  wire [3*DW-1:0]   fund_active_in,
  input  wire [3*DW-1:0]   fund_reactive_in,
  input  wire [3*DW-1:0]   apparent_in,
  output wire [3*DW-1:0]   cal_volt,
  output wire [3*DW-1:0]   cal_curr,
  output wire [3*DW-1:0]   cal_active,
  output wire [3*DW-1:0]   cal_fund_active,
  output wire [3*DW-1:0]   cal_fund_reactive,
  output wire [3*DW-1:0]   cal_apparent,
  output wire [2:0]        energy_pulse_output,
  output wire [2:0]        reactive_pulse_output
);

  // --------------------------------------------------------------------------
  // Shared registers
  // --------------------------------------------------------------------------
  // The threshold is shared by all phases; a new setting acts on the next sample.
  reg  [7:0]  energy_threshold_setting_ff;
  wire [34:0] threshold = {energy_threshold_setting_ff, {`ECD_THR_LOW{1'b0}}};

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      energy_threshold_setting_ff <= `ECD_THR_RST;
    end else if (reg_wr && reg_addr == `ECD_THR_SET) begin
      energy_threshold_setting_ff <= reg_wdata[7:0];
    end
  end

  wire [3*32-1:0] rd_ph;

  // --------------------------------------------------------------------------
  // Per-phase logic
  // --------------------------------------------------------------------------
  // Phases differ only in their address constants.
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_ph
      wire [15:0] a_gain = (p == 0) ? `ECD_PGAIN_A : (p == 1) ? `ECD_PGAIN_B : `ECD_PGAIN_C;
      wire [15:0] a_wos  = (p == 0) ? `ECD_WOS_A : (p == 1) ? `ECD_WOS_B : `ECD_WOS_C;
      wire [15:0] a_fwos = (p == 0) ? `ECD_FWOS_A : (p == 1) ? `ECD_FWOS_B : `ECD_FWOS_C;
      wire [15:0] a_fvar = (p == 0) ? `ECD_FVAROS_A : (p == 1) ? `ECD_FVAROS_B
                                                               : `ECD_FVAROS_C;
      wire [15:0] a_dcmp = (p == 0) ? `ECD_DCOMP_A : (p == 1) ? `ECD_DCOMP_B : `ECD_DCOMP_C;
      wire [15:0] a_div  = (p == 0) ? `ECD_DIV_A : (p == 1) ? `ECD_DIV_B : `ECD_DIV_C;
      wire [15:0] a_irms = (p == 0) ? `ECD_IRMS_A : (p == 1) ? `ECD_IRMS_B : `ECD_IRMS_C;
      wire [15:0] a_vrms = (p == 0) ? `ECD_VRMS_A : (p == 1) ? `ECD_VRMS_B : `ECD_VRMS_C;

      reg  [23:0] power_gain_ff;
      reg  [23:0] active_offset_ff;
      reg  [23:0] fund_active_offset_ff;
      reg  [23:0] fund_reactive_offset_ff;
      reg  [9:0]  delay_comp_ff;
      reg  [15:0] pulse_rate_divider_ff;
      reg  [DW-1:0] irms_ff;
      reg  [DW-1:0] vrms_ff;

      // ------------------------------
      // Address decode of this phase
      // ------------------------------
      wire          hit_gain = (reg_addr == a_gain);
      wire          hit_wos  = (reg_addr == a_wos);
      wire          hit_fwos = (reg_addr == a_fwos);
      wire          hit_fvar = (reg_addr == a_fvar);
      wire          hit_dcmp = (reg_addr == a_dcmp);
      wire          hit_div  = (reg_addr == a_div);
      wire          hit_irms = (reg_addr == a_irms);
      wire          hit_vrms = (reg_addr == a_vrms);

      // ------------------------------
      // Output slices of this phase
      // ------------------------------
      // Each phase owns its own slice, so every output bit has one driver.
      reg  [DW-1:0] cal_volt_ff;
      reg  [DW-1:0] cal_curr_ff;
      reg  [DW-1:0] cal_active_ff;
      reg  [DW-1:0] cal_fund_active_ff;
      reg  [DW-1:0] cal_fund_reactive_ff;
      reg  [DW-1:0] cal_apparent_ff;

      assign cal_volt[p*DW +: DW]          = cal_volt_ff;
      assign cal_curr[p*DW +: DW]          = cal_curr_ff;
      assign cal_active[p*DW +: DW]        = cal_active_ff;
      assign cal_fund_active[p*DW +: DW]   = cal_fund_active_ff;
      assign cal_fund_reactive[p*DW +: DW] = cal_fund_reactive_ff;
      assign cal_apparent[p*DW +: DW]      = cal_apparent_ff;

      // ------------------------------
      // Correction registers
      // ------------------------------

      // Host writes land at once and act from the next sample on.
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          power_gain_ff           <= 24'h000000;
          active_offset_ff        <= 24'h000000;
          fund_active_offset_ff   <= 24'h000000;
          fund_reactive_offset_ff <= 24'h000000;
          delay_comp_ff           <= 10'h000;
          pulse_rate_divider_ff   <= `ECD_DIV_RST;
        end else if (reg_wr) begin
          if (hit_gain) begin
            power_gain_ff <= reg_wdata[23:0];
          end
          if (hit_wos) begin
            active_offset_ff <= reg_wdata[23:0];
          end
          if (hit_fwos) begin
            fund_active_offset_ff <= reg_wdata[23:0];
          end
          if (hit_fvar) begin
            fund_reactive_offset_ff <= reg_wdata[23:0];
          end
          if (hit_dcmp) begin
            delay_comp_ff <= reg_wdata[9:0];
          end
          if (hit_div) begin
            pulse_rate_divider_ff <= reg_wdata[15:0];
          end
        end
      end

      // ------------------------------
      // Delay lines
      // ------------------------------
      // Delay lines hold the last DEPTH samples of voltage and current.
      // The memories are not reset, so a delayed path shows stale words
      // until as many samples as the delay steps have passed.

      reg [DW-1:0] vbuf [0:DEPTH-1];
      reg [DW-1:0] ibuf [0:DEPTH-1];
      reg [8:0]    wptr_ff;
      wire [8:0]   steps = delay_comp_ff[8:0];
      wire         pos_err = delay_comp_ff[`ECD_DCOMP_POS];
      wire [8:0]   rptr = wptr_ff - steps;
      wire [DW-1:0] v_now = volt_in[p*DW +: DW];
      wire [DW-1:0] i_now = curr_in[p*DW +: DW];
      // A positive error delays the current, otherwise the voltage is delayed.
      wire [DW-1:0] v_al = (pos_err || steps == 9'h000) ? v_now : vbuf[rptr];
      wire [DW-1:0] i_al = (pos_err && steps != 9'h000) ? ibuf[rptr] : i_now;

      always @(posedge clock) begin
        if (sample_valid) begin
          vbuf[wptr_ff] <= v_now;
          ibuf[wptr_ff] <= i_now;
        end
      end

      // ------------------------------
      // Gain and offsets
      // ------------------------------
      // Offsets wrap rather than saturate; software keeps them small.

      // Gain as a signed 26-bit multiplier of value 2^23 + gain.
      wire signed [DW-1:0] pv = $signed(v_al);
      wire signed [DW-1:0] pi = $signed(i_al);
      wire signed [2*DW-1:0] pwr_raw = pv * pi;
      wire signed [DW-1:0] pwr = pwr_raw[2*DW-2 -: DW];
      wire signed [25:0] mult = $signed({2'b00, 24'h800000}) +
                                $signed({{2{power_gain_ff[23]}}, power_gain_ff});

      function [DW-1:0] ecd_scale;
        input signed [DW-1:0] x;
        input signed [25:0]   m;
        input signed [23:0]   os;
        reg signed [DW+25:0]  prod;
        begin
          prod = x * m;
          ecd_scale = prod[DW-1+`ECD_GAIN_FRAC:`ECD_GAIN_FRAC] +
                      {{(DW-24){os[23]}}, os};
        end
      endfunction

      reg [35:0] acc_act_ff;
      reg [35:0] acc_rea_ff;
      reg [15:0] cnt_act_ff;
      reg [15:0] cnt_rea_ff;
      reg        pul_act_ff;
      reg        pul_rea_ff;

      // ------------------------------
      // Sample update
      // ------------------------------


      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          wptr_ff                      <= 9'h000;
          cal_volt_ff                  <= {DW{1'b0}};
          cal_curr_ff                  <= {DW{1'b0}};
          cal_active_ff                <= {DW{1'b0}};
          cal_fund_active_ff           <= {DW{1'b0}};
          cal_fund_reactive_ff         <= {DW{1'b0}};
          cal_apparent_ff              <= {DW{1'b0}};
          irms_ff                      <= {DW{1'b0}};
          vrms_ff                      <= {DW{1'b0}};
        end else if (sample_valid) begin
          wptr_ff                      <= wptr_ff + 9'h001;
          cal_volt_ff                  <= v_al;
          cal_curr_ff                  <= i_al;
          cal_active_ff                <= ecd_scale(pwr, mult, active_offset_ff);
          cal_fund_active_ff           <= ecd_scale($signed(fund_active_in[p*DW +: DW]),
                                                    mult, fund_active_offset_ff);
          cal_fund_reactive_ff         <= ecd_scale($signed(fund_reactive_in[p*DW +: DW]),
                                                    mult, fund_reactive_offset_ff);
          cal_apparent_ff              <= ecd_scale($signed(apparent_in[p*DW +: DW]),
                                                    mult, 24'h000000);
          irms_ff                      <= curr_rms_in[p*DW +: DW];
          vrms_ff                      <= volt_rms_in[p*DW +: DW];
        end
      end

      // ------------------------------
      // Energy accumulation
      // ------------------------------
      // 36 bits leave room for one full sample above the largest threshold.
      // A divider of zero or one passes every crossing on as a pulse.

      // Energy accumulation: magnitudes add up until the threshold, then one
      // internal pulse; the divider turns these into output pulses.
      wire [DW-1:0] a_val = cal_active[p*DW +: DW];
      wire [DW-1:0] r_val = cal_fund_reactive[p*DW +: DW];
      wire [DW-1:0] a_mag = a_val[DW-1] ? (~a_val + 1'b1) : a_val;
      wire [DW-1:0] r_mag = r_val[DW-1] ? (~r_val + 1'b1) : r_val;
      wire [35:0] nxt_acc_act = acc_act_ff + {{(36-DW){1'b0}}, a_mag};
      wire [35:0] nxt_acc_rea = acc_rea_ff + {{(36-DW){1'b0}}, r_mag};
      wire hit_act = nxt_acc_act >= {1'b0, threshold};
      wire hit_rea = nxt_acc_rea >= {1'b0, threshold};

      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          acc_act_ff <= 36'h0;
          acc_rea_ff <= 36'h0;
          cnt_act_ff <= 16'h0000;
          cnt_rea_ff <= 16'h0000;
          pul_act_ff <= 1'b0;
          pul_rea_ff <= 1'b0;
        end else begin
          pul_act_ff <= 1'b0;
          pul_rea_ff <= 1'b0;
          if (sample_valid) begin
            if (hit_act) begin
              acc_act_ff <= nxt_acc_act - {1'b0, threshold};
            end else begin
              acc_act_ff <= nxt_acc_act;
            end
            if (hit_rea) begin
              acc_rea_ff <= nxt_acc_rea - {1'b0, threshold};
            end else begin
              acc_rea_ff <= nxt_acc_rea;
            end
            if (hit_act) begin
              if (cnt_act_ff + 16'h0001 >= pulse_rate_divider_ff) begin
                cnt_act_ff <= 16'h0000;
                pul_act_ff <= 1'b1;
              end else begin
                cnt_act_ff <= cnt_act_ff + 16'h0001;
              end
            end
            if (hit_rea) begin
              if (cnt_rea_ff + 16'h0001 >= pulse_rate_divider_ff) begin
                cnt_rea_ff <= 16'h0000;
                pul_rea_ff <= 1'b1;
              end else begin
                cnt_rea_ff <= cnt_rea_ff + 16'h0001;
              end
            end
          end
        end
      end

      // ------------------------------
      // Pulse outputs
      // ------------------------------

      // Both pulse kinds run side by side so phase error shows in one reading.
      assign energy_pulse_output[p]   = pul_act_ff;
      assign reactive_pulse_output[p] = pul_rea_ff;

      // ------------------------------
      // Read selection
      // ------------------------------
      reg [31:0] rd_sel;
      always @* begin
        rd_sel = 32'h00000000;
        if (hit_gain) begin
          rd_sel = {8'h00, power_gain_ff};
        end
        if (hit_wos) begin
          rd_sel = {8'h00, active_offset_ff};
        end
        if (hit_fwos) begin
          rd_sel = {8'h00, fund_active_offset_ff};
        end
        if (hit_fvar) begin
          rd_sel = {8'h00, fund_reactive_offset_ff};
        end
        if (hit_dcmp) begin
          rd_sel = {22'h0, delay_comp_ff};
        end
        if (hit_div) begin
          rd_sel = {16'h0000, pulse_rate_divider_ff};
        end
        if (hit_irms) begin
          rd_sel = {{(32-DW){1'b0}}, irms_ff};
        end
        if (hit_vrms) begin
          rd_sel = {{(32-DW){1'b0}}, vrms_ff};
        end
      end

      assign rd_ph[p*32 +: 32] = rd_sel;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  // Unmapped addresses read as zero, and so does the port outside a read answer.
  wire [31:0] rd_thr = (reg_addr == `ECD_THR_SET) ? {24'h000000, energy_threshold_setting_ff}
                                                  : 32'h00000000;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_ph[31:0] | rd_ph[63:32] | rd_ph[95:64] | rd_thr;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // ecd_datapath

//--- verif/ecd_datapath_chk.sv
// Port checker of the calibration datapath, bound into every instance of it.
// Assumes no register write lands in the same cycle as a sample strobe.
`include "ecd_map.vh"
module ecd_chk #(
  parameter DW    = 24,
  parameter DEPTH = 512
) (
  input wire logic            clock,
  input wire logic            sys_rst,
  input wire logic [15:0]     reg_addr,
  input wire logic [31:0]     reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [31:0]     reg_rdata,
  input wire logic            sample_valid,
  input wire logic [3*DW-1:0] apparent_in,
  input wire logic [3*DW-1:0] cal_apparent,
  input wire logic [3*DW-1:0] cal_fund_active,
  input wire logic [2:0]      energy_pulse_output,
  input wire logic [2:0]      reactive_pulse_output
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Shadow of the phase A gain, so the scaled power can be predicted.
  logic signed [23:0] gain_ff;
  wire  signed [25:0] gmul = 26'sh800000 + gain_ff;
  wire  signed [49:0] prod = $signed(apparent_in[23:0]) * gmul;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst) gain_ff <= 24'h000000;
    else if (reg_wr && reg_addr == `ECD_PGAIN_A) gain_ff <= reg_wdata[23:0];
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data not zero outside a read answer");
  a_upper_clear: assert property ($past(reg_rd) |-> reg_rdata[31:24] == 8'h00)
    else $error("read data upper byte not zero");
  a_delay_width: assert property ($past(reg_rd) && $past(reg_addr) == `ECD_DCOMP_A
    |-> reg_rdata[31:10] == 22'h0) else $error("delay field wider than ten bits");
  a_thr_width: assert property ($past(reg_rd) && $past(reg_addr) == `ECD_THR_SET
    |-> reg_rdata[31:8] == 24'h000000) else $error("threshold setting wider than eight bits");
  a_gain_scale: assert property (sample_valid |=> cal_apparent[23:0] == $past(prod[46:23]))
    else $error("apparent power not scaled by the phase gain");
  a_cal_hold: assert property (!sample_valid |=> $stable(cal_fund_active))
    else $error("calibrated power moved without a sample");
  a_pulse_cause: assert property (|energy_pulse_output |-> $past(sample_valid))
    else $error("energy pulse without a preceding sample");
  a_react_cause: assert property (|reactive_pulse_output |-> $past(sample_valid))
    else $error("reactive pulse without a preceding sample");
  cover property (|reactive_pulse_output);
  cover property (energy_pulse_output[0] && reactive_pulse_output[0]);
  cover property ($past(reg_rd) && $past(reg_addr) == `ECD_IRMS_A);
endmodule // ecd_chk

bind ecd_datapath ecd_chk #(.DW(DW), .DEPTH(DEPTH)) i_ecd_chk (
  .clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid,
  .apparent_in, .cal_apparent, .cal_fund_active, .energy_pulse_output, .reactive_pulse_output
);

//--- verif/ecd_host.sv
// Host model driving the register port of the calibration datapath.
// Assumes every task is entered just after a rising clock edge.
module ecd_host (
  input  wire logic        clock,
  output logic      [15:0] reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // A gap cycle follows each write so the strobe is never set twice in one step.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
endmodule // ecd_host

//--- verif/testbench.sv
// Self-checking bench of the calibration datapath; the host model owns the register port.
// Assumes the register map header and the bound port checker are compiled beside it.
`include "ecd_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sample_valid = 1'b0;
  logic [71:0] volt_in = '0, curr_in = '0, vrms = '0, irms = '0, fa = '0, fr = '0, ap = '0;
  wire  [15:0] reg_addr;
  wire  [31:0] reg_wdata, reg_rdata;
  wire         reg_wr, reg_rd;
  wire  [71:0] c_v, c_i, c_a, c_fa, c_fr, c_ap;
  wire  [2:0]  e_p, r_p;
  int          fail_count = 0, total_checks = 0, rp_a, rp_b, en_a;
  logic [31:0] lfsr_ff = 32'h00017f2b;
  logic [15:0] adr [19] = '{`ECD_PGAIN_A, `ECD_WOS_A, `ECD_PGAIN_B, `ECD_WOS_B, `ECD_PGAIN_C,
    `ECD_WOS_C, `ECD_FWOS_A, `ECD_FWOS_B, `ECD_FWOS_C, `ECD_FVAROS_A, `ECD_FVAROS_B,
    `ECD_FVAROS_C, `ECD_DCOMP_A, `ECD_DCOMP_B, `ECD_DCOMP_C, `ECD_THR_SET, `ECD_DIV_A,
    `ECD_DIV_B, `ECD_DIV_C};
  always #25 clock = ~clock;
  ecd_host i_ecd_host (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  ecd_datapath i_ecd_datapath (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sample_valid, .volt_in, .curr_in, .volt_rms_in(vrms), .curr_rms_in(irms),
    .fund_active_in(fa), .fund_reactive_in(fr), .apparent_in(ap), .cal_volt(c_v),
    .cal_curr(c_i), .cal_active(c_a), .cal_fund_active(c_fa), .cal_fund_reactive(c_fr),
    .cal_apparent(c_ap), .energy_pulse_output(e_p), .reactive_pulse_output(r_p));
  function automatic logic [31:0] rnd();
    lfsr_ff = {lfsr_ff[30:0], ^(lfsr_ff & 32'h80200003)};
    return lfsr_ff;
  endfunction
  function automatic logic [23:0] scale(input logic [23:0] x, g, o);
    longint p;
    p = longint'($signed(x)) * (longint'($signed(g)) + 64'sh800000);
    return 24'(p >>> 23) + o;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic smp();
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (r_p[0] === 1'b1) rp_a++;
    if (r_p[1] === 1'b1) rp_b++;
    if (e_p[0] === 1'b1) en_a++;
  end
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    give_verdict();
  end
  initial begin
    logic [31:0] d, m [19];
    logic [23:0] g [3], o [3], q [3];
    logic [71:0] lv, li, vh [$], ch [$];
    longint      acc;
    int          cnt, ep;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    // ------------------------------------------------------------------
    // Register defaults, width masking and an unmapped place.
    // ------------------------------------------------------------------
    for (int i = 0; i < 19; i++) begin
      i_ecd_host.rd(adr[i], d);
      chk("default", d, i == 15 ? 32'h3 : i > 15 ? 32'hdb3 : 32'h0);
      m[i] = rnd();
      i_ecd_host.wr(adr[i], m[i]);
    end
    for (int i = 0; i < 19; i++) begin
      i_ecd_host.rd(adr[i], d);
      chk("readback", d, m[i] & ((32'h1 << (i < 12 ? 24 : i < 15 ? 10 : i == 15 ? 8 : 16)) - 1));
    end
    i_ecd_host.rd(16'h4400, d);
    chk("unmapped", d, 32'h0);
    // ------------------------------------------------------------------
    // Per-phase gain and offsets, with rms capture on the sample only.
    // ------------------------------------------------------------------
    for (int p = 0; p < 3; p++) begin
      g[p] = 24'(rnd());
      o[p] = 24'(rnd());
      q[p] = 24'(rnd());
      i_ecd_host.wr(`ECD_PGAIN_A + 16'(2 * p), {8'h00, g[p]});
      i_ecd_host.wr(`ECD_FWOS_A + 16'(p), {8'h00, o[p]});
      i_ecd_host.wr(`ECD_FVAROS_A + 16'(p), {8'h00, q[p]});
    end
    repeat (6) begin
      fa <= 72'({rnd(), rnd(), rnd()});
      fr <= 72'({rnd(), rnd(), rnd()});
      ap <= 72'({rnd(), rnd(), rnd()});
      vrms <= 72'({rnd(), rnd(), rnd()});
      irms <= 72'({rnd(), rnd(), rnd()});
      smp();
      lv = vrms;
      li = irms;
      vrms <= ~lv;
      for (int p = 0; p < 3; p++) begin
        chk("apparent", c_ap[24*p+:24], scale(ap[24*p+:24], g[p], 24'h0));
        chk("fund_act", c_fa[24*p+:24], scale(fa[24*p+:24], g[p], o[p]));
        chk("fund_react", c_fr[24*p+:24], scale(fr[24*p+:24], g[p], q[p]));
        i_ecd_host.rd(`ECD_IRMS_A + 16'(2 * p), d);
        chk("irms", d, {8'h00, li[24*p+:24]});
        i_ecd_host.rd(`ECD_VRMS_A + 16'(2 * p), d);
        chk("vrms", d, {8'h00, lv[24*p+:24]});
      end
    end
    // ------------------------------------------------------------------
    // Delay steps: current late on A, voltage late on B, none on C.
    // ------------------------------------------------------------------
    i_ecd_host.wr(`ECD_DCOMP_A, 32'h203);
    i_ecd_host.wr(`ECD_DCOMP_B, 32'h005);
    i_ecd_host.wr(`ECD_DCOMP_C, 32'h000);
    for (int k = 0; k < 12; k++) begin
      vh.push_back(72'({rnd(), rnd(), rnd()}));
      ch.push_back(72'({rnd(), rnd(), rnd()}));
      volt_in <= vh[k];
      curr_in <= ch[k];
      smp();
      if (k >= 5) begin
        chk("curr_a", c_i[23:0], ch[k-3][23:0]);
        chk("volt_a", c_v[23:0], vh[k][23:0]);
        chk("volt_b", c_v[47:24], vh[k-5][47:24]);
        chk("curr_c", c_i[71:48], ch[k][71:48]);
        chk("active_c", c_a[71:48], scale(24'((longint'($signed(vh[k][71:48])) *
          longint'($signed(ch[k][71:48]))) >>> 23), g[2], m[5][23:0]));
      end
    end
    // ------------------------------------------------------------------
    // Second reset, then pulses from a pure offset and a reactive load.
    // ------------------------------------------------------------------
    sys_rst <= 1'b1;
    rp_a = 0;
    rp_b = 0;
    en_a = 0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    i_ecd_host.wr(`ECD_THR_SET, 32'h1);
    i_ecd_host.wr(`ECD_DIV_A, 32'h2);
    i_ecd_host.wr(`ECD_WOS_A, 32'h7fffff);
    volt_in <= '0;
    curr_in <= {3{24'h000010}};
    fr <= 72'h7fffff;
    acc = 0;
    cnt = 0;
    ep = 0;
    repeat (70) begin
      smp();
      acc += 64'h7fffff;
      if (acc >= 64'h8000000) begin
        acc -= 64'h8000000;
        cnt++;
        if (cnt >= 2) begin
          ep++;
          cnt = 0;
        end
      end
    end
    repeat (2) @(posedge clock);
    chk("react_pulses", rp_a, ep);
    chk("energy_pulses", en_a, ep);
    chk("react_b_pulses", rp_b, 0);
    give_verdict();
  end
endmodule // testbench
